/* hdl/cache_pkg.sv */
// Operation
// R1: Reset clears the whole control word.
// R2: Reset leaves tags, states, data alone.
// R3: Software invalidates everything before enabling.
// R4: Privileged push selects line by index.
// R5: Push invalidates unless no-invalidate bit set.
// R6: 128 sets of four lines, 512 lines.
// R7: Push and invalidate ignore the enable.
// R8: Disabled cache keeps contents, bypasses accesses.
// R9: Index bits 10:4 set, 3:0 line; the code takes the line from bits 1:0.
// R10: 16-byte lines, 8K, whole-line fills.
// R11: Valid and dirty flags give three states.
// R12: Policy from region entry, else default.
// R13: Copyback misses fetch a full line.
// R14: Fill prefers an invalid line, sets valid.
// R15: Full set uses pseudo round robin victim.
// R16: Dirty victim buffered, written after fill.
// R17: Write-through lines never become modified.
// R18: Write-through write miss goes memory only.
// R19: Write-through hit updates memory and line.
// R20: Copyback write hit marks line modified.
// R21: Invalidate discards modified data, no writeback.
// R22: Whole invalidate clears all, self-clears, stalls.
// R23: Hit needs valid line with equal tag.
package cache_pkg;
   localparam int          SETS          = 128;
   localparam int          WAYS          = 4;
   localparam int          LINE_W        = 128;
   localparam int          TAG_W         = 21;
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_REGION0   = 8'h04;
   localparam logic [7:0]  OFS_REGION1   = 8'h08;
   localparam logic [7:0]  OFS_PUSH      = 8'h0C;
   localparam logic [7:0]  OFS_STATUS    = 8'h10;
   localparam int          CTRL_ENABLE   = 31;
   localparam int          CTRL_NOINV    = 28;
   localparam int          CTRL_INVAL    = 24;
   localparam int          CTRL_POL_LSB  = 8;
   localparam logic [31:0] CTRL_WMASK    = 32'h9100_0300;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
   localparam int          RGN_BASE_LSB  = 24;
   localparam int          RGN_MASK_LSB  = 16;
   localparam int          RGN_EN        = 15;
   localparam int          RGN_MODE_LSB  = 13;
   localparam int          RGN_POL_LSB   = 5;
   localparam logic [31:0] RGN_WMASK     = 32'hFFFF_E064;
   localparam int          PUSH_SET_LSB  = 4;
   localparam int          PUSH_IDX_W    = 11;
   localparam logic [1:0]  POL_WT        = 2'h0;
   localparam logic [1:0]  POL_CB        = 2'h1;
   typedef enum logic [3:0] {
      S_IDLE, S_INVAL, S_PUSH, S_PUSHWR, S_BYPASS, S_WTWR, S_FILL, S_CPBK, S_DONE
   } state_t;
endpackage : cache_pkg

/* hdl/line_store.sv */
`timescale 1ns/10ps
module line_store #(
   parameter int SETS   = 128,
   parameter int WAYS   = 4,
   parameter int TAG_W  = 21,
   parameter int LINE_W = 128
) (
   input  wire logic                             clk,
   input  wire logic [$clog2(SETS)-1:0]          idx,
   input  wire logic                             wrEn,
   input  wire logic [$clog2(WAYS)-1:0]          wrWay,
   input  wire logic [TAG_W-1:0]                 wrTag,
   input  wire logic [LINE_W-1:0]                wrData,
   input  wire logic                             wrValid,
   input  wire logic                             wrDirty,
   input  wire logic                             clrEn,
   output logic      [WAYS-1:0][TAG_W-1:0]       rdTag,
   output logic      [WAYS-1:0][LINE_W-1:0]      rdData,
   output logic      [WAYS-1:0]                  rdValid,
   output logic      [WAYS-1:0]                  rdDirty
);
   // No reset on any array; contents survive reset (see R2)
   for (genvar w = 0; w < WAYS; w++) begin : g_way
      logic [TAG_W-1:0]  tagMem  [SETS];
      logic [LINE_W-1:0] dataMem [SETS];
      logic [SETS-1:0]   validMem;
      logic [SETS-1:0]   dirtyMem;
      always_ff @(posedge clk) begin
         if (clrEn) begin
            validMem[idx] <= 1'b0; // see R21
            dirtyMem[idx] <= 1'b0;
         end else if (wrEn && wrWay == w) begin
            tagMem[idx]   <= wrTag;
            dataMem[idx]  <= wrData;
            validMem[idx] <= wrValid; // see R11
            dirtyMem[idx] <= wrDirty;
         end
      end
      assign rdTag[w]   = tagMem[idx];
      assign rdData[w]  = dataMem[idx];
      assign rdValid[w] = validMem[idx];
      assign rdDirty[w] = dirtyMem[idx];
   end
endmodule : line_store

/* hdl/unified_cache_line_manager.sv */
`timescale 1ns/10ps
module unified_cache_line_manager (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [7:0]   regAddr,
   input  wire logic [31:0]  regWData,
   input  wire logic         regWr,
   input  wire logic         regRd,
   input  wire logic         regPriv,
   output logic      [31:0]  regRData,
   input  wire logic         coreReq,
   input  wire logic         coreWrite,
   input  wire logic         coreSuper,
   input  wire logic [31:0]  coreAddr,
   input  wire logic [31:0]  coreWData,
   output logic              coreReady,
   output logic      [31:0]  coreRData,
   output logic              memReq,
   output logic              memWrite,
   output logic              memLine,
   output logic      [31:0]  memAddr,
   output logic      [127:0] memWData,
   input  wire logic         memAck,
   input  wire logic [127:0] memRData
);
   typedef struct packed {
      cache_pkg::state_t state;
      logic [31:0]       ctrl;
      logic [1:0][31:0]  region;
      logic [10:0]       pushIdx;
      logic              pushPend;
      logic              pushRej;
      logic [1:0]        rrPtr;
      logic [127:0]      buffer;
      logic [31:0]       bufAddr;
      logic              bufPend;
      logic [1:0]        way;
      logic [31:0]       addr;
      logic [31:0]       wdata;
      logic              write;
      logic              wtMode;
      logic [6:0]        invSet;
      logic              memReq;
      logic              memWrite;
      logic              memLine;
      logic [31:0]       memAddr;
      logic [127:0]      memWData;
      logic              coreReady;
      logic [31:0]       coreRData;
      logic [31:0]       regRData;
   } regs_t;

   regs_t st;
   regs_t next_st;

   logic [6:0]        idx;
   logic              wrEn;
   logic [1:0]        wrWay;
   logic [20:0]       wrTag;
   logic [127:0]      wrData;
   logic              wrValid;
   logic              wrDirty;
   logic              clrEn;
   logic [3:0][20:0]  rdTag;
   logic [3:0][127:0] rdData;
   logic [3:0]        rdValid;
   logic [3:0]        rdDirty;
   logic              hit;
   logic [1:0]        hitWay;
   logic [1:0]        victimWay;
   logic              allFull;
   logic [1:0]        policy;
   logic              cacheable;
   logic              cbMode;

   function automatic logic [127:0] merge(input logic [127:0] line, input logic [1:0] sel,
                                          input logic [31:0] word);
      logic [127:0] res;
      res = line;
      res[sel*32 +: 32] = word;
      return res;
   endfunction : merge

   function automatic logic [31:0] pick(input logic [127:0] line, input logic [1:0] sel);
      return line[sel*32 +: 32];
   endfunction : pick

   line_store #(
      .SETS   (cache_pkg::SETS),
      .WAYS   (cache_pkg::WAYS),
      .TAG_W  (cache_pkg::TAG_W),
      .LINE_W (cache_pkg::LINE_W)
   ) u_store (
      .clk     (clk),
      .idx     (idx),
      .wrEn    (wrEn),
      .wrWay   (wrWay),
      .wrTag   (wrTag),
      .wrData  (wrData),
      .wrValid (wrValid),
      .wrDirty (wrDirty),
      .clrEn   (clrEn),
      .rdTag   (rdTag),
      .rdData  (rdData),
      .rdValid (rdValid),
      .rdDirty (rdDirty)
   );

   way_select #(
      .WAYS  (cache_pkg::WAYS),
      .TAG_W (cache_pkg::TAG_W)
   ) u_sel (
      .tags      (rdTag),
      .valid     (rdValid),
      .addrTag   (coreAddr[31:11]),
      .rrPtr     (st.rrPtr),
      .hit       (hit),
      .hitWay    (hitWay),
      .victimWay (victimWay),
      .allFull   (allFull)
   );

   // Set index into the directory (see R6)
   always_comb begin
      if (st.state == cache_pkg::S_IDLE) begin
         idx = st.pushPend ? st.pushIdx[10:4] : coreAddr[10:4]; // see R9
      end else if (st.state == cache_pkg::S_INVAL) begin
         idx = st.invSet;
      end else begin
         idx = st.addr[10:4];
      end
   end

   // Region lookup, entry 0 wins on overlap
   always_comb begin
      policy = st.ctrl[cache_pkg::CTRL_POL_LSB +: 2]; // see R12
      for (int i = 1; i >= 0; i--) begin
         if (st.region[i][cache_pkg::RGN_EN]
             && ((coreAddr[31:24] ^ st.region[i][cache_pkg::RGN_BASE_LSB +: 8])
                 & ~st.region[i][cache_pkg::RGN_MASK_LSB +: 8]) == 8'h00
             && (st.region[i][cache_pkg::RGN_MODE_LSB + 1]
                 || st.region[i][cache_pkg::RGN_MODE_LSB] == coreSuper)) begin
            policy = st.region[i][cache_pkg::RGN_POL_LSB +: 2];
         end
      end
      cacheable = st.ctrl[cache_pkg::CTRL_ENABLE] && !policy[1]; // see R8
      cbMode    = policy == cache_pkg::POL_CB;
   end

   always_comb begin
      next_st           = st;
      next_st.coreReady = 1'b0;
      wrEn              = 1'b0;
      clrEn             = 1'b0;
      wrWay             = st.way;
      wrTag             = st.addr[31:11];
      wrData            = rdData[st.way];
      wrValid           = 1'b1;
      wrDirty           = 1'b0;
      case (st.state)
         cache_pkg::S_IDLE: begin
            if (st.ctrl[cache_pkg::CTRL_INVAL]) begin
               next_st.invSet = 7'h00; // see R7
               next_st.state  = cache_pkg::S_INVAL;
            end else if (st.pushPend) begin
               next_st.pushPend = 1'b0;
               next_st.addr     = {21'h000000, st.pushIdx[10:4], 4'h0}; // see R4
               next_st.way      = st.pushIdx[1:0];
               next_st.state    = cache_pkg::S_PUSH;
            end else if (coreReq) begin
               next_st.addr   = coreAddr;
               next_st.wdata  = coreWData;
               next_st.write  = coreWrite;
               next_st.wtMode = !cbMode;
               if (!cacheable) begin
                  next_st.memReq   = 1'b1;
                  next_st.memWrite = coreWrite;
                  next_st.memLine  = 1'b0;
                  next_st.memAddr  = coreAddr;
                  next_st.memWData = {96'h0, coreWData};
                  next_st.state    = cache_pkg::S_BYPASS;
               end else if (hit) begin
                  next_st.way = hitWay;
                  if (!coreWrite) begin
                     next_st.coreRData = pick(rdData[hitWay], coreAddr[3:2]);
                     next_st.coreReady = 1'b1;
                     next_st.state     = cache_pkg::S_DONE;
                  end else begin
                     wrEn    = 1'b1;
                     wrWay   = hitWay;
                     wrTag   = coreAddr[31:11];
                     wrData  = merge(rdData[hitWay], coreAddr[3:2], coreWData);
                     wrDirty = cbMode; // see R20 see R17
                     if (cbMode) begin
                        next_st.coreReady = 1'b1;
                        next_st.state     = cache_pkg::S_DONE;
                     end else begin
                        next_st.memReq   = 1'b1; // see R19
                        next_st.memWrite = 1'b1;
                        next_st.memLine  = 1'b0;
                        next_st.memAddr  = coreAddr;
                        next_st.memWData = {96'h0, coreWData};
                        next_st.state    = cache_pkg::S_WTWR;
                     end
                  end
               end else if (coreWrite && !cbMode) begin
                  next_st.memReq   = 1'b1; // see R18
                  next_st.memWrite = 1'b1;
                  next_st.memLine  = 1'b0;
                  next_st.memAddr  = coreAddr;
                  next_st.memWData = {96'h0, coreWData};
                  next_st.state    = cache_pkg::S_WTWR;
               end else begin
                  next_st.way = victimWay; // see R14
                  if (allFull) begin
                     next_st.rrPtr = st.rrPtr + 2'h1; // see R15
                  end
                  if (rdValid[victimWay] && rdDirty[victimWay]) begin
                     next_st.buffer  = rdData[victimWay]; // see R16
                     next_st.bufAddr = {rdTag[victimWay], coreAddr[10:4], 4'h0};
                     next_st.bufPend = 1'b1;
                  end
                  next_st.memReq   = 1'b1; // see R13
                  next_st.memWrite = 1'b0;
                  next_st.memLine  = 1'b1;
                  next_st.memAddr  = {coreAddr[31:4], 4'h0}; // see R10
                  next_st.state    = cache_pkg::S_FILL;
               end
            end
         end
         cache_pkg::S_INVAL: begin
            clrEn          = 1'b1; // see R22
            next_st.invSet = st.invSet + 7'h01;
            if (st.invSet == 7'h7F) begin
               next_st.ctrl[cache_pkg::CTRL_INVAL] = 1'b0;
               next_st.state = cache_pkg::S_IDLE;
            end
         end
         cache_pkg::S_PUSH: begin
            wrTag = rdTag[st.way];
            if (rdValid[st.way] && rdDirty[st.way]) begin
               next_st.memReq   = 1'b1; // see R4
               next_st.memWrite = 1'b1;
               next_st.memLine  = 1'b1;
               next_st.memAddr  = {rdTag[st.way], st.addr[10:4], 4'h0};
               next_st.memWData = rdData[st.way];
               next_st.state    = cache_pkg::S_PUSHWR;
            end else begin
               wrEn          = 1'b1;
               wrValid       = rdValid[st.way] && st.ctrl[cache_pkg::CTRL_NOINV]; // see R5
               next_st.state = cache_pkg::S_IDLE;
            end
         end
         cache_pkg::S_PUSHWR: begin
            wrTag = rdTag[st.way];
            if (memAck) begin
               next_st.memReq = 1'b0;
               wrEn           = 1'b1;
               wrValid        = st.ctrl[cache_pkg::CTRL_NOINV]; // see R5
               next_st.state  = cache_pkg::S_IDLE;
            end
         end
         cache_pkg::S_BYPASS: begin
            if (memAck) begin
               next_st.memReq = 1'b0;
               if (!st.write) begin
                  next_st.coreRData = memRData[31:0];
               end
               next_st.coreReady = 1'b1;
               next_st.state     = cache_pkg::S_DONE;
            end
         end
         cache_pkg::S_WTWR: begin
            if (memAck) begin
               next_st.memReq    = 1'b0;
               next_st.coreReady = 1'b1;
               next_st.state     = cache_pkg::S_DONE;
            end
         end
         cache_pkg::S_FILL: begin
            if (memAck) begin
               next_st.memReq = 1'b0;
               wrEn           = 1'b1; // see R14
               wrData         = st.write ? merge(memRData, st.addr[3:2], st.wdata) : memRData;
               wrDirty        = st.write && !st.wtMode; // see R17
               next_st.coreRData = pick(memRData, st.addr[3:2]);
               if (st.bufPend) begin
                  next_st.memReq   = 1'b1; // see R16
                  next_st.memWrite = 1'b1;
                  next_st.memLine  = 1'b1;
                  next_st.memAddr  = st.bufAddr;
                  next_st.memWData = st.buffer;
                  next_st.state    = cache_pkg::S_CPBK;
               end else begin
                  next_st.coreReady = 1'b1;
                  next_st.state     = cache_pkg::S_DONE;
               end
            end
         end
         cache_pkg::S_CPBK: begin
            if (memAck) begin
               next_st.memReq    = 1'b0;
               next_st.bufPend   = 1'b0;
               next_st.coreReady = 1'b1;
               next_st.state     = cache_pkg::S_DONE;
            end
         end
         cache_pkg::S_DONE: begin
            next_st.state = cache_pkg::S_IDLE;
         end
         default: begin
            next_st.state = cache_pkg::S_IDLE;
         end
      endcase
      // Register port; a set request wins over the hardware clear above
      next_st.regRData = 32'h0000_0000;
      if (regRd) begin
         case (regAddr)
            cache_pkg::OFS_CTRL:    next_st.regRData = st.ctrl;
            cache_pkg::OFS_REGION0: next_st.regRData = st.region[0];
            cache_pkg::OFS_REGION1: next_st.regRData = st.region[1];
            cache_pkg::OFS_PUSH:    next_st.regRData = {21'h000000, st.pushIdx};
            cache_pkg::OFS_STATUS:  next_st.regRData = {28'h0000000, st.pushRej, st.bufPend,
                                                        st.pushPend,
                                                        st.state != cache_pkg::S_IDLE};
            default:                next_st.regRData = 32'h0000_0000;
         endcase
      end
      if (regWr) begin
         case (regAddr)
            cache_pkg::OFS_CTRL: begin
               next_st.ctrl = (regWData & cache_pkg::CTRL_WMASK)
                            | (next_st.ctrl & (32'h1 << cache_pkg::CTRL_INVAL)); // see R3
            end
            cache_pkg::OFS_REGION0: next_st.region[0] = regWData & cache_pkg::RGN_WMASK;
            cache_pkg::OFS_REGION1: next_st.region[1] = regWData & cache_pkg::RGN_WMASK;
            cache_pkg::OFS_PUSH: begin
               if (regPriv) begin
                  next_st.pushIdx  = regWData[cache_pkg::PUSH_IDX_W-1:0]; // see R9
                  next_st.pushPend = 1'b1;
                  next_st.pushRej  = 1'b0;
               end else begin
                  next_st.pushRej  = 1'b1; // see R4
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0; // see R1
      end else begin
         st <= next_st;
      end
   end

   assign regRData  = st.regRData;
   assign coreReady = st.coreReady;
   assign coreRData = st.coreRData;
   assign memReq    = st.memReq;
   assign memWrite  = st.memWrite;
   assign memLine   = st.memLine;
   assign memAddr   = st.memAddr;
   assign memWData  = st.memWData;

   a_wt_never_dirty: assert property (@(posedge clk) disable iff (!rst_b) // see R17
      wrEn && st.state == cache_pkg::S_FILL |-> !(wrDirty && st.wtMode))
      else $error("write-through line made dirty");
   a_cb_hit_dirty: assert property (@(posedge clk) disable iff (!rst_b) // see R20
      st.state == cache_pkg::S_IDLE && !st.ctrl[24] && !st.pushPend && coreReq && coreWrite
      && cacheable && cbMode && hit |-> wrEn && wrDirty ##1 coreReady)
      else $error("copyback write hit not marked modified");
   a_push_writes_line: assert property (@(posedge clk) disable iff (!rst_b) // see R4
      st.state == cache_pkg::S_PUSH && rdValid[st.way] && rdDirty[st.way]
      |=> memReq && memWrite && memLine && st.state == cache_pkg::S_PUSHWR)
      else $error("dirty push line not written back");
   a_push_invalidates: assert property (@(posedge clk) disable iff (!rst_b) // see R5
      st.state == cache_pkg::S_PUSHWR && memAck
      |-> wrEn && wrValid == st.ctrl[cache_pkg::CTRL_NOINV] && !wrDirty)
      else $error("push left wrong line state");
   a_fill_whole_line: assert property (@(posedge clk) disable iff (!rst_b) // see R10
      st.state == cache_pkg::S_FILL |-> memReq && memLine && !memWrite && memAddr[3:0] == 4'h0)
      else $error("fill is not a whole aligned line");
   a_copyback_after: assert property (@(posedge clk) disable iff (!rst_b) // see R16
      st.state == cache_pkg::S_FILL && memAck && st.bufPend
      |=> st.state == cache_pkg::S_CPBK && memAddr == $past(st.bufAddr) && !coreReady)
      else $error("victim not written after fill");
   a_inval_sweep: assert property (@(posedge clk) disable iff (!rst_b) // see R22
      st.state == cache_pkg::S_IDLE && st.ctrl[cache_pkg::CTRL_INVAL]
      |=> clrEn && st.invSet == 7'h00 ##127 clrEn && st.invSet == 7'h7F ##1
          st.state == cache_pkg::S_IDLE)
      else $error("whole invalidate sweep wrong length");
   a_disabled_bypass: assert property (@(posedge clk) disable iff (!rst_b) // see R8
      st.state == cache_pkg::S_IDLE && !st.ctrl[cache_pkg::CTRL_INVAL] && !st.pushPend
      && coreReq && !st.ctrl[cache_pkg::CTRL_ENABLE]
      |-> !wrEn ##1 st.state == cache_pkg::S_BYPASS && memReq && !memLine)
      else $error("disabled cache touched the line store");
   a_wt_miss_no_alloc: assert property (@(posedge clk) disable iff (!rst_b) // see R18
      st.state == cache_pkg::S_WTWR |-> !wrEn && !memLine && memWrite)
      else $error("write-through write allocated a line");
endmodule : unified_cache_line_manager

/* hdl/way_select.sv */
`timescale 1ns/10ps
module way_select #(
   parameter int WAYS  = 4,
   parameter int TAG_W = 21
) (
   input  wire logic [WAYS-1:0][TAG_W-1:0] tags,
   input  wire logic [WAYS-1:0]            valid,
   input  wire logic [TAG_W-1:0]           addrTag,
   input  wire logic [$clog2(WAYS)-1:0]    rrPtr,
   output logic                            hit,
   output logic      [$clog2(WAYS)-1:0]    hitWay,
   output logic      [$clog2(WAYS)-1:0]    victimWay,
   output logic                            allFull
);
   logic [WAYS-1:0] match;
   for (genvar w = 0; w < WAYS; w++) begin : g_cmp
      assign match[w] = valid[w] && tags[w] == addrTag; // see R23
   end
   always_comb begin
      hit       = |match;
      hitWay    = '0;
      allFull   = &valid;
      victimWay = rrPtr; // see R15
      for (int w = WAYS - 1; w >= 0; w--) begin
         if (match[w]) begin
            hitWay = w[$clog2(WAYS)-1:0];
         end
         if (!valid[w]) begin
            victimWay = w[$clog2(WAYS)-1:0]; // see R14
         end
      end
   end
endmodule : way_select

/* verif/mem_model.sv */
`timescale 1ns/10ps
module mem_model (
   input  wire logic         clk,
   input  wire logic         memReq,
   input  wire logic         memWrite,
   input  wire logic [31:0]  memAddr,
   output logic              memAck,
   output logic      [127:0] memRData,
   output int                rdCount,
   output int                wrCount,
   output logic      [31:0]  wrAddr
);
   logic [1:0]   waitCnt;
   logic [127:0] line;
   // Each word holds its own address
   assign line = {memAddr + 32'hC, memAddr + 32'h8, memAddr + 32'h4, memAddr};
   // Data only meaningful in the ack cycle
   assign memRData = memAck ? line : ~line;
   initial begin
      memAck = 1'b0;
      waitCnt = 2'h0;
      rdCount = 0;
      wrCount = 0;
      wrAddr = 32'h0;
   end
   // Slow answer, three cycles after the request
   always @(posedge clk) begin
      memAck <= 1'b0;
      if (memReq && !memAck) begin
         waitCnt <= waitCnt + 2'h1;
         if (waitCnt == 2'h2) begin
            memAck <= 1'b1;
            waitCnt <= 2'h0;
            if (memWrite) begin
               wrCount <= wrCount + 1;
               wrAddr <= memAddr;
            end else begin
               rdCount <= rdCount + 1;
            end
         end
      end
   end
endmodule : mem_model

/* verif/unified_cache_line_manager_tb.sv */
`timescale 1ns/10ps
module unified_cache_line_manager_tb;
   logic clk, rst_b, regWr, regRd, regPriv, coreReq, coreWrite, coreReady, coreSuper;
   logic memReq, memWrite, memLine, memAck;
   logic [7:0] regAddr;
   logic [31:0] regWData, regRData, coreAddr, coreWData, coreRData, memAddr, wrAddr, d;
   logic [127:0] memWData, memRData;
   int rdCount, wrCount, mismatches, total_checks;
   unified_cache_line_manager dut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
      .regWData(regWData), .regWr(regWr), .regRd(regRd), .regPriv(regPriv),
      .regRData(regRData), .coreReq(coreReq), .coreWrite(coreWrite), .coreSuper(coreSuper),
      .coreAddr(coreAddr), .coreWData(coreWData), .coreReady(coreReady),
      .coreRData(coreRData), .memReq(memReq), .memWrite(memWrite), .memLine(memLine),
      .memAddr(memAddr), .memWData(memWData), .memAck(memAck), .memRData(memRData));
   mem_model mem (.clk(clk), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
      .memAck(memAck), .memRData(memRData), .rdCount(rdCount), .wrCount(wrCount),
      .wrAddr(wrAddr));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic regW(input logic [7:0] a, input logic [31:0] v, input logic p);
      @(posedge clk);
      regAddr <= a;
      regWData <= v;
      regPriv <= p;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : regW
   task automatic regR(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 v = regRData;
   endtask : regR
   task automatic core(input logic w, input logic [31:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk);
      coreReq <= 1'b1;
      coreWrite <= w;
      coreAddr <= a;
      coreWData <= wd;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (coreReady !== 1'b1 && n < 200);
      d = coreRData;
      coreReq <= 1'b0;
      if (n >= 200) begin
         mismatches++;
         $display("wrong value at %0t: core access timed out", $time);
      end
   endtask : core
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      give_verdict();
   end
   initial begin
      {rst_b, regWr, regRd, regPriv, coreReq, coreWrite, coreSuper} = '0;
      {regAddr, regWData, coreAddr, coreWData} = '0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      regR(cache_pkg::OFS_CTRL, d); chk(d, 32'h0);
      regW(cache_pkg::OFS_CTRL, 32'h0100_0000, 1'b1);
      regR(cache_pkg::OFS_CTRL, d); chk(d, 32'h0100_0000);
      repeat (135) @(posedge clk);
      regR(cache_pkg::OFS_CTRL, d); chk(d, 32'h0);
      regW(cache_pkg::OFS_CTRL, 32'h8000_0100, 1'b1);
      core(1'b0, 32'h1234, 32'h0); chk(d, 32'h1234); chk(rdCount, 1);
      core(1'b0, 32'h1238, 32'h0); chk(d, 32'h1238); chk(rdCount, 1);
      core(1'b1, 32'h1234, 32'hCAFE_0001);
      core(1'b0, 32'h1234, 32'h0); chk(d, 32'hCAFE_0001); chk(wrCount, 0);
      for (int w = 0; w < 4; w++) begin
         regW(cache_pkg::OFS_PUSH, 32'h230 | w, 1'b1);
         repeat (15) @(posedge clk);
      end
      chk(wrCount, 1); chk(wrAddr, 32'h1230); chk(memWData[63:32], 32'hCAFE_0001);
      core(1'b0, 32'h1234, 32'h0); chk(d, 32'h1234); chk(rdCount, 2);
      regW(cache_pkg::OFS_CTRL, 32'h0, 1'b1);
      core(1'b0, 32'h1238, 32'h0); chk(d, 32'h1238); chk(rdCount, 3);
      chk(memLine, 1'b0);
      regW(cache_pkg::OFS_REGION0, 32'h0000_8000, 1'b1);
      regW(cache_pkg::OFS_CTRL, 32'h8000_0100, 1'b1);
      core(1'b1, 32'h1234, 32'h5555_0002); chk(wrCount, 2); chk(wrAddr, 32'h1234);
      core(1'b0, 32'h1234, 32'h0); chk(d, 32'h5555_0002); chk(rdCount, 3);
      core(1'b1, 32'h5670, 32'h1); chk(wrCount, 3);
      core(1'b0, 32'h5670, 32'h0); chk(d, 32'h5670); chk(rdCount, 4);
      coreSuper <= 1'b1;
      for (int i = 0; i < 5; i++) core(1'b1, 32'h1230 + i * 32'h800, i);
      chk(wrCount, 4); chk(wrAddr, 32'h1230); chk(memWData[63:32], 32'h5555_0002);
      core(1'b1, 32'h3A30, 32'h5); chk(wrAddr, 32'h1A30); chk(rdCount, 9);
      rst_b <= 1'b0;
      @(posedge clk);
      rst_b <= 1'b1;
      regW(cache_pkg::OFS_CTRL, 32'h8000_0100, 1'b1);
      core(1'b0, 32'h3A30, 32'h0); chk(d, 32'h5); chk(rdCount, 9);
      regW(cache_pkg::OFS_PUSH, 32'h0, 1'b0);
      regR(cache_pkg::OFS_STATUS, d); chk(d & 32'h8, 32'h8);
      regR(8'hF0, d); chk(d, 32'h0);
      give_verdict();
   end
endmodule : unified_cache_line_manager_tb
